/* design/lmr_pkg.sv */
// constants and types for the partial-refresh and dq-training mode register group
`default_nettype none

package lmr_pkg;

	// ==========================================================
	// widths
	localparam int unsigned ADDR_W = 6;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned BANK_W = 3;
	localparam int unsigned ROW_W  = 15;
	localparam int unsigned OSC_W  = 16;

	// ==========================================================
	// mode register addresses
	localparam logic [5:0] MA_BANK_MASK = 6'h10;
	localparam logic [5:0] MA_SEG_MASK  = 6'h11;
	localparam logic [5:0] MA_OSC_LOW   = 6'h12;
	localparam logic [5:0] MA_OSC_HIGH  = 6'h13;
	localparam logic [5:0] MA_INVERT    = 6'h14;
	localparam logic [5:0] MA_RSVD      = 6'h15;
	localparam logic [5:0] MA_TERM      = 6'h16;

	// ==========================================================
	// reset values
	localparam logic [7:0] BANK_MASK_RST = 8'h00;
	localparam logic [7:0] SEG_MASK_RST  = 8'h00;
	localparam logic [7:0] INVERT_RST    = 8'h55;
	localparam logic [7:0] TERM_RST      = 8'h00;
	localparam logic [7:0] READ_ZERO     = 8'h00;
	localparam logic [15:0] OSC_RST      = 16'h0000;

	// ==========================================================
	// field positions
	localparam int unsigned SEG_ROW_MSB  = 14;
	localparam int unsigned SEG_ROW_LSB  = 12;
	localparam int unsigned OSC_LOW_LSB  = 0;
	localparam int unsigned OSC_HIGH_LSB = 8;
	localparam int unsigned TERM_SEL_LSB = 0;
	localparam int unsigned TERM_CK_BIT  = 3;
	localparam int unsigned TERM_CS_BIT  = 4;
	localparam int unsigned TERM_CA_BIT  = 5;
	localparam int unsigned TERM_BYTE_LSB = 6;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic [5:0] addr;
		logic [7:0] op;
	} lmr_mrcmd_t;

	// layout follows the termination register bit order, msb first
	typedef struct packed {
		logic [1:0] byte_mode_termination;
		logic       command_address_termination_disable;
		logic       chip_select_termination_enable;
		logic       clock_termination_enable;
		logic [2:0] controller_termination_select;
	} lmr_term_t;

	typedef struct packed {
		logic [7:0] bank_refresh_mask;
		logic [7:0] segment_refresh_mask;
		logic [7:0] upper_byte_cal_invert;
	} lmr_cfg_t;

endpackage : lmr_pkg

`default_nettype wire

/* design/lmr_word_cross.sv */
// handshake crossing that keeps resending a word from one clock domain to another
`default_nettype none

module lmr_word_cross #(
	parameter int unsigned WIDTH = 8
) (
	input  wire logic             src_clk,
	input  wire logic             dst_clk,
	input  wire logic             rst_b,
	input  wire logic [WIDTH-1:0] src_data,
	output logic      [WIDTH-1:0] dst_data
);

	// ==========================================================
	// source side
	logic [WIDTH-1:0] hold;
	logic             req_tog;
	logic             ack_meta;
	logic             ack_sync;
	logic             ack_tog;

	// hold only changes once the previous word has been acknowledged
	always_ff @(posedge src_clk or negedge rst_b) begin
		if (!rst_b) begin
			hold    <= '0;
			req_tog <= 1'b0;
		end else if (ack_sync == req_tog) begin
			hold    <= src_data;
			req_tog <= ~req_tog;
		end
	end

	always_ff @(posedge src_clk or negedge rst_b) begin
		if (!rst_b) begin
			ack_meta <= 1'b0;
			ack_sync <= 1'b0;
		end else begin
			ack_meta <= ack_tog;
			ack_sync <= ack_meta;
		end
	end

	// ==========================================================
	// destination side
	logic req_meta;
	logic req_sync;

	always_ff @(posedge dst_clk or negedge rst_b) begin
		if (!rst_b) begin
			req_meta <= 1'b0;
			req_sync <= 1'b0;
		end else begin
			req_meta <= req_tog;
			req_sync <= req_meta;
		end
	end

	always_ff @(posedge dst_clk or negedge rst_b) begin
		if (!rst_b) begin
			dst_data <= '0;
			ack_tog  <= 1'b0;
		end else if (req_sync != ack_tog) begin
			dst_data <= hold;
			ack_tog  <= req_sync;
		end
	end

endmodule : lmr_word_cross

`default_nettype wire

/* design/lmr_cal_invert.sv */
// upper-byte read calibration pattern driver with per-line inversion
`default_nettype none

module lmr_cal_invert (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic       cal_active,
	input  wire logic       pattern_bit,
	input  wire logic [7:0] invert_mask,
	input  wire logic       dbi_enable,
	output logic      [7:0] dq_pattern,
	output logic            mask_line,
	output logic            dbi_apply
);

	// ==========================================================
	// per-line inversion
	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_line
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					dq_pattern[i] <= 1'b0;
				end else begin
					dq_pattern[i] <= cal_active & (pattern_bit ^ invert_mask[i]);
				end
			end
		end
	endgenerate

	// ==========================================================
	// mask line and bus inversion
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mask_line <= 1'b0;
			dbi_apply <= 1'b0;
		end else begin
			mask_line <= cal_active & pattern_bit;
			dbi_apply <= dbi_enable & ~cal_active;
		end
	end

endmodule : lmr_cal_invert

`default_nettype wire

/* design/lmr_mode_regs.sv */
// mode register group: refresh masks, dqs oscillator count, calibration invert, termination
`default_nettype none

module lmr_mode_regs (
	input  wire logic               CORE_CLK,
	input  wire logic               RST_B,
	input  wire logic               LINK_CLK,
	input  wire logic               MRW_STROBE,
	input  wire lmr_pkg::lmr_mrcmd_t MRW_CMD,
	input  wire logic               MRR_STROBE,
	input  wire logic [5:0]         MRR_ADDR,
	input  wire logic               MPC_OSC_START,
	input  wire logic               WRITE_SET_POINT_SELECT,
	input  wire logic               OPERATE_SET_POINT_SELECT,
	output logic [7:0]              MRR_DATA,
	output logic                    MRR_VALID,
	output lmr_pkg::lmr_term_t      TERM_ACTIVE,
	input  wire logic               OSC_TICK,
	input  wire logic               OSC_RUN,
	input  wire logic               SREF_CHECK,
	input  wire logic [2:0]         SREF_BANK,
	input  wire logic [14:0]        SREF_ROW,
	output logic                    SREF_ALLOW,
	output logic                    SREF_VALID,
	input  wire logic               CAL_ACTIVE,
	input  wire logic               CAL_PATTERN_BIT,
	input  wire logic               DBI_ENABLE,
	output logic [7:0]              UPPER_DQ_PATTERN,
	output logic                    UPPER_MASK_INVERSION_LINE,
	output logic                    DBI_APPLY
);

	// ==========================================================
	// link domain: write decode
	logic [7:0]         bank_refresh_mask;
	logic [7:0]         segment_refresh_mask;
	logic [7:0]         upper_byte_cal_invert;
	lmr_pkg::lmr_term_t termination_control [2];

	logic wr_bank;
	logic wr_seg;
	logic wr_inv;
	logic wr_term;

	assign wr_bank = MRW_STROBE && (MRW_CMD.addr == lmr_pkg::MA_BANK_MASK);
	assign wr_seg  = MRW_STROBE && (MRW_CMD.addr == lmr_pkg::MA_SEG_MASK);
	assign wr_inv  = MRW_STROBE && (MRW_CMD.addr == lmr_pkg::MA_INVERT);
	assign wr_term = MRW_STROBE && (MRW_CMD.addr == lmr_pkg::MA_TERM);
	// reserved and read-only addresses match no write enable

	always_ff @(posedge LINK_CLK or negedge RST_B) begin
		if (!RST_B) begin
			bank_refresh_mask <= lmr_pkg::BANK_MASK_RST;
		end else if (wr_bank) begin
			bank_refresh_mask <= MRW_CMD.op;
		end
	end

	always_ff @(posedge LINK_CLK or negedge RST_B) begin
		if (!RST_B) begin
			segment_refresh_mask <= lmr_pkg::SEG_MASK_RST;
		end else if (wr_seg) begin
			segment_refresh_mask <= MRW_CMD.op;
		end
	end

	always_ff @(posedge LINK_CLK or negedge RST_B) begin
		if (!RST_B) begin
			upper_byte_cal_invert <= lmr_pkg::INVERT_RST;
		end else if (wr_inv) begin
			upper_byte_cal_invert <= MRW_CMD.op;
		end
	end

	// only the write set point copy is written
	always_ff @(posedge LINK_CLK or negedge RST_B) begin
		if (!RST_B) begin
			termination_control[0] <= lmr_pkg::TERM_RST;
			termination_control[1] <= lmr_pkg::TERM_RST;
		end else if (wr_term) begin
			termination_control[WRITE_SET_POINT_SELECT] <= MRW_CMD.op;
		end
	end

	// the inactive copy may change freely; only the operating copy reaches the pads
	always_ff @(posedge LINK_CLK or negedge RST_B) begin
		if (!RST_B) begin
			TERM_ACTIVE <= lmr_pkg::TERM_RST;
		end else begin
			TERM_ACTIVE <= termination_control[OPERATE_SET_POINT_SELECT];
		end
	end

	// ==========================================================
	// link domain: oscillator start event
	logic osc_start_tog;

	always_ff @(posedge LINK_CLK or negedge RST_B) begin
		if (!RST_B) begin
			osc_start_tog <= 1'b0;
		end else if (MPC_OSC_START) begin
			osc_start_tog <= ~osc_start_tog;
		end
	end

	// ==========================================================
	// link domain: read path
	logic [15:0] osc_count_link;
	logic [7:0]  dqs_osc_count_low;
	logic [7:0]  dqs_osc_count_high;
	logic [7:0]  next_mrr_data;
	logic [7:0]  term_read;

	assign dqs_osc_count_low  = osc_count_link[lmr_pkg::OSC_LOW_LSB +: 8];
	assign dqs_osc_count_high = osc_count_link[lmr_pkg::OSC_HIGH_LSB +: 8];
	// the write set point picks the copy a read reaches, as it does for writes
	assign term_read          = termination_control[WRITE_SET_POINT_SELECT];

	// write-only and reserved registers read as zero, except termination
	always_comb begin
		next_mrr_data = lmr_pkg::READ_ZERO;
		case (MRR_ADDR)
			lmr_pkg::MA_OSC_LOW: begin
				next_mrr_data = dqs_osc_count_low;
			end
			lmr_pkg::MA_OSC_HIGH: begin
				next_mrr_data = dqs_osc_count_high;
			end
			// read the write set point copy
			lmr_pkg::MA_TERM: begin
				next_mrr_data = term_read;
			end
			default: begin
				next_mrr_data = lmr_pkg::READ_ZERO;
			end
		endcase
	end

	always_ff @(posedge LINK_CLK or negedge RST_B) begin
		if (!RST_B) begin
			MRR_DATA  <= lmr_pkg::READ_ZERO;
			MRR_VALID <= 1'b0;
		end else begin
			MRR_VALID <= MRR_STROBE;
			if (MRR_STROBE) begin
				MRR_DATA <= next_mrr_data;
			end
		end
	end

	// ==========================================================
	// crossings
	lmr_pkg::lmr_cfg_t cfg_link;
	lmr_pkg::lmr_cfg_t cfg_core;
	lmr_pkg::lmr_cfg_t cfg_link_rel;
	lmr_pkg::lmr_cfg_t cfg_core_rel;
	logic [15:0]       osc_count;

	localparam lmr_pkg::lmr_cfg_t CFG_RST = '{bank_refresh_mask:     lmr_pkg::BANK_MASK_RST,
	                                          segment_refresh_mask:  lmr_pkg::SEG_MASK_RST,
	                                          upper_byte_cal_invert: lmr_pkg::INVERT_RST};

	assign cfg_link = '{bank_refresh_mask:     bank_refresh_mask,
	                    segment_refresh_mask:  segment_refresh_mask,
	                    upper_byte_cal_invert: upper_byte_cal_invert};

	// crossing carries the difference from reset, so the core sees reset values before a word lands
	assign cfg_link_rel = cfg_link ^ CFG_RST;
	assign cfg_core     = cfg_core_rel ^ CFG_RST;

	// config words follow a write within a few round trips of both clocks
	lmr_word_cross #(
		.WIDTH ($bits(lmr_pkg::lmr_cfg_t))
	) u_cfg_cross (
		.src_clk  (LINK_CLK),
		.dst_clk  (CORE_CLK),
		.rst_b    (RST_B),
		.src_data (cfg_link_rel),
		.dst_data (cfg_core_rel)
	);

	// both count bytes travel as one word, so osc_count_link never mixes two counts
	lmr_word_cross #(
		.WIDTH (lmr_pkg::OSC_W)
	) u_osc_cross (
		.src_clk  (CORE_CLK),
		.dst_clk  (LINK_CLK),
		.rst_b    (RST_B),
		.src_data (osc_count),
		.dst_data (osc_count_link)
	);

	// ==========================================================
	// core domain: oscillator counter
	logic start_meta;
	logic start_sync;
	logic start_seen;
	logic osc_start;

	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			start_meta <= 1'b0;
			start_sync <= 1'b0;
			start_seen <= 1'b0;
		end else begin
			start_meta <= osc_start_tog;
			start_sync <= start_meta;
			start_seen <= start_sync;
		end
	end

	assign osc_start = start_sync ^ start_seen;

	logic osc_full;
	logic osc_step;

	// a full count holds rather than wrapping to a small, plausible value
	assign osc_full = &osc_count;
	assign osc_step = OSC_RUN && OSC_TICK && !osc_full;

	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			osc_count <= lmr_pkg::OSC_RST;
		end else if (osc_start) begin
			osc_count <= lmr_pkg::OSC_RST;
		end else if (osc_step) begin
			osc_count <= osc_count + 16'h0001;
		end
	end

	// ==========================================================
	// core domain: partial-array refresh check
	logic [2:0] seg_index;
	logic       bank_skip;
	logic       seg_skip;

	assign seg_index = SREF_ROW[lmr_pkg::SEG_ROW_MSB:lmr_pkg::SEG_ROW_LSB];
	assign bank_skip = cfg_core.bank_refresh_mask[SREF_BANK];
	assign seg_skip  = cfg_core.segment_refresh_mask[seg_index];

	// single-channel die: this channel's own masks are the only ones consulted
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			SREF_ALLOW <= 1'b0;
			SREF_VALID <= 1'b0;
		end else begin
			SREF_VALID <= SREF_CHECK;
			if (SREF_CHECK) begin
				SREF_ALLOW <= ~bank_skip & ~seg_skip;
			end
		end
	end

	// ==========================================================
	// core domain: read calibration output
	lmr_cal_invert u_cal (
		.clk         (CORE_CLK),
		.rst_b       (RST_B),
		.cal_active  (CAL_ACTIVE),
		.pattern_bit (CAL_PATTERN_BIT),
		.invert_mask (cfg_core.upper_byte_cal_invert),
		.dbi_enable  (DBI_ENABLE),
		.dq_pattern  (UPPER_DQ_PATTERN),
		.mask_line   (UPPER_MASK_INVERSION_LINE),
		.dbi_apply   (DBI_APPLY)
	);

endmodule : lmr_mode_regs

`default_nettype wire

/* verification/lmr_mode_regs_sva.sv */
// checker: port-level timing of the mode register group
`default_nettype none

module lmr_mode_regs_sva (
	input wire logic       CORE_CLK,
	input wire logic       RST_B,
	input wire logic       LINK_CLK,
	input wire logic       MRR_STROBE,
	input wire logic [5:0] MRR_ADDR,
	input wire logic [7:0] MRR_DATA,
	input wire logic       MRR_VALID,
	input wire logic       SREF_CHECK,
	input wire logic       SREF_ALLOW,
	input wire logic       SREF_VALID,
	input wire logic       CAL_ACTIVE,
	input wire logic       CAL_PATTERN_BIT,
	input wire logic       DBI_ENABLE,
	input wire logic [7:0] UPPER_DQ_PATTERN,
	input wire logic       UPPER_MASK_INVERSION_LINE,
	input wire logic       DBI_APPLY
);
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================================
	// link side
	sequence s_read_answer;
		##1 MRR_VALID;
	endsequence
	property p_read_answer;
		@(posedge LINK_CLK) disable iff (!RST_B) MRR_STROBE |-> s_read_answer;
	endproperty
	a_read_answer: assert property (p_read_answer)
		else $error("read not answered one cycle later");
	property p_read_idle;
		@(posedge LINK_CLK) disable iff (!RST_B) !MRR_STROBE |=> !MRR_VALID && $stable(MRR_DATA);
	endproperty
	a_read_idle: assert property (p_read_idle)
		else $error("read data moved without a read");
	property p_rsvd_zero;
		@(posedge LINK_CLK) disable iff (!RST_B)
			MRR_STROBE && MRR_ADDR == lmr_pkg::MA_RSVD |=> MRR_DATA == 8'h00;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero)
		else $error("reserved slot read not zero");
	property p_mask_zero;
		@(posedge LINK_CLK) disable iff (!RST_B) MRR_STROBE
			&& (MRR_ADDR == lmr_pkg::MA_BANK_MASK || MRR_ADDR == lmr_pkg::MA_SEG_MASK) |=> MRR_DATA == 8'h00;
	endproperty
	a_mask_zero: assert property (p_mask_zero)
		else $error("write-only mask readable");
	// ==========================================================
	// core side
	sequence s_sref_answer;
		##1 SREF_VALID;
	endsequence
	property p_sref_answer;
		@(posedge CORE_CLK) disable iff (!RST_B) SREF_CHECK |-> s_sref_answer;
	endproperty
	a_sref_answer: assert property (p_sref_answer)
		else $error("refresh query not answered");
	property p_sref_hold;
		@(posedge CORE_CLK) disable iff (!RST_B) !SREF_CHECK |=> !SREF_VALID && $stable(SREF_ALLOW);
	endproperty
	a_sref_hold: assert property (p_sref_hold)
		else $error("refresh answer changed without query");
	property p_dbi;
		@(posedge CORE_CLK) disable iff (!RST_B) 1'b1 |=> DBI_APPLY == ($past(DBI_ENABLE) && !$past(CAL_ACTIVE));
	endproperty
	a_dbi: assert property (p_dbi)
		else $error("bus inversion wrong around calibration");
	property p_mask_line;
		@(posedge CORE_CLK) disable iff (!RST_B)
			1'b1 |=> UPPER_MASK_INVERSION_LINE == ($past(CAL_ACTIVE) && $past(CAL_PATTERN_BIT));
	endproperty
	a_mask_line: assert property (p_mask_line)
		else $error("mask line not the true pattern");
	property p_cal_idle;
		@(posedge CORE_CLK) disable iff (!RST_B) !CAL_ACTIVE |=> UPPER_DQ_PATTERN == 8'h00;
	endproperty
	a_cal_idle: assert property (p_cal_idle)
		else $error("pattern driven outside calibration");
endmodule : lmr_mode_regs_sva

bind lmr_mode_regs lmr_mode_regs_sva u_sva (
	.CORE_CLK(CORE_CLK), .RST_B(RST_B), .LINK_CLK(LINK_CLK), .MRR_STROBE(MRR_STROBE),
	.MRR_ADDR(MRR_ADDR), .MRR_DATA(MRR_DATA), .MRR_VALID(MRR_VALID), .SREF_CHECK(SREF_CHECK),
	.SREF_ALLOW(SREF_ALLOW), .SREF_VALID(SREF_VALID), .CAL_ACTIVE(CAL_ACTIVE),
	.CAL_PATTERN_BIT(CAL_PATTERN_BIT), .DBI_ENABLE(DBI_ENABLE), .UPPER_DQ_PATTERN(UPPER_DQ_PATTERN),
	.UPPER_MASK_INVERSION_LINE(UPPER_MASK_INVERSION_LINE), .DBI_APPLY(DBI_APPLY)
);

`default_nettype wire

/* verification/lmr_ctrl_model.sv */
// memory controller model issuing mode register commands on the link clock
`default_nettype none

module lmr_ctrl_model #(
	parameter bit ODD_DENSITY = 1'b0
) (
	input  wire logic          link_clk,
	input  wire logic [7:0]    mrr_data,
	input  wire logic          mrr_valid,
	output logic               mrw_strobe,
	output lmr_pkg::lmr_mrcmd_t mrw_cmd,
	output logic               mrr_strobe,
	output logic [5:0]         mrr_addr,
	output logic               osc_start,
	output logic               wsp,
	output logic               osp
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		mrw_strobe = 1'b0;
		mrw_cmd = '0;
		mrr_strobe = 1'b0;
		mrr_addr = 6'h00;
		osc_start = 1'b0;
		wsp = 1'b0;
		osp = 1'b0;
	end
	task automatic mrw(input logic [5:0] a, input logic [7:0] op);
		if (ODD_DENSITY && a == lmr_pkg::MA_SEG_MASK) op[7:6] = 2'b00;
		@(posedge link_clk);
		mrw_strobe <= 1'b1;
		mrw_cmd <= '{addr: a, op: op};
		@(posedge link_clk);
		mrw_strobe <= 1'b0;
		// released bus shows the inverted command, not the last command
		mrw_cmd <= lmr_pkg::lmr_mrcmd_t'(~{a, op});
	endtask : mrw
	task automatic mrr(input logic [5:0] a, output logic [7:0] d, output logic v);
		@(posedge link_clk);
		mrr_strobe <= 1'b1;
		mrr_addr <= a;
		@(posedge link_clk);
		mrr_strobe <= 1'b0;
		mrr_addr <= ~a;
		#1;
		v = mrr_valid;
		d = mrr_data;
	endtask : mrr
	task automatic rd_count(output logic [15:0] c, output logic v);
		logic vh;
		logic vl;
		mrr(lmr_pkg::MA_OSC_HIGH, c[15:8], vh);
		mrr(lmr_pkg::MA_OSC_LOW, c[7:0], vl);
		v = vh & vl;
	endtask : rd_count
	task automatic start_osc();
		@(posedge link_clk);
		osc_start <= 1'b1;
		@(posedge link_clk);
		osc_start <= 1'b0;
	endtask : start_osc
	task automatic set_sp(input logic w, input logic o);
		@(posedge link_clk);
		wsp <= w;
		osp <= o;
	endtask : set_sp
endmodule : lmr_ctrl_model

`default_nettype wire

/* verification/tb.sv */
// self-checking testbench of the mode register group
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk = 1'b0, link_clk = 1'b0, rst_b = 1'b0;
	logic osc_tick = 1'b0, osc_run = 1'b0, sref_check = 1'b0;
	logic cal_active = 1'b0, cal_pattern_bit = 1'b0, dbi_enable = 1'b0;
	logic [2:0] sref_bank = 3'h0;
	logic [14:0] sref_row = 15'h0000;
	logic mrw_strobe, mrr_strobe, osc_start, wsp, osp, mrr_valid, sref_allow, sref_valid, mask_line, dbi_apply;
	logic [5:0] mrr_addr;
	logic [7:0] mrr_data, upper_dq;
	lmr_pkg::lmr_mrcmd_t mrw_cmd;
	lmr_pkg::lmr_term_t term_active;
	logic [31:0] seed = 32'hC558;
	int failures = 0, check_count = 0, bm = 0, sm = 0, inv = 32'h55;
	int term [2];
	logic [5:0] wo_addr [6] = '{lmr_pkg::MA_BANK_MASK, lmr_pkg::MA_SEG_MASK, lmr_pkg::MA_OSC_LOW,
		lmr_pkg::MA_INVERT, lmr_pkg::MA_RSVD, 6'h3F};
	always #4 core_clk = ~core_clk;
	// 30 ns link period never shares a rising edge with the core clock
	always #15 link_clk = ~link_clk;
	lmr_mode_regs u_dut (
		.CORE_CLK(core_clk), .RST_B(rst_b), .LINK_CLK(link_clk), .MRW_STROBE(mrw_strobe), .MRW_CMD(mrw_cmd),
		.MRR_STROBE(mrr_strobe), .MRR_ADDR(mrr_addr), .MPC_OSC_START(osc_start), .WRITE_SET_POINT_SELECT(wsp),
		.OPERATE_SET_POINT_SELECT(osp), .MRR_DATA(mrr_data), .MRR_VALID(mrr_valid), .TERM_ACTIVE(term_active),
		.OSC_TICK(osc_tick), .OSC_RUN(osc_run), .SREF_CHECK(sref_check), .SREF_BANK(sref_bank),
		.SREF_ROW(sref_row), .SREF_ALLOW(sref_allow), .SREF_VALID(sref_valid), .CAL_ACTIVE(cal_active),
		.CAL_PATTERN_BIT(cal_pattern_bit), .DBI_ENABLE(dbi_enable), .UPPER_DQ_PATTERN(upper_dq),
		.UPPER_MASK_INVERSION_LINE(mask_line), .DBI_APPLY(dbi_apply));
	lmr_ctrl_model u_mc (.link_clk(link_clk), .mrr_data(mrr_data), .mrr_valid(mrr_valid),
		.mrw_strobe(mrw_strobe), .mrw_cmd(mrw_cmd), .mrr_strobe(mrr_strobe), .mrr_addr(mrr_addr),
		.osc_start(osc_start), .wsp(wsp), .osp(osp));
	// ==========================================================
	// helpers
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : conclude
	// config crosses to the core domain before use
	task automatic settle();
		repeat (60) @(posedge core_clk);
	endtask : settle
	task automatic sref(input logic [2:0] b, input logic [14:0] r);
		@(posedge core_clk);
		sref_check <= 1'b1;
		sref_bank <= b;
		sref_row <= r;
		@(posedge core_clk);
		sref_check <= 1'b0;
		sref_bank <= ~b;
		sref_row <= ~r;
		#1;
		chk("sref_valid", 16'(sref_valid), 16'h0001);
		chk("sref_allow", 16'(sref_allow), 16'(!bm[b] && !sm[r[14:12]]));
	endtask : sref
	task automatic cal();
		logic p;
		for (int i = 0; i < 8; i++) begin
			p = rnd() % 2;
			@(posedge core_clk);
			cal_active <= 1'b1;
			dbi_enable <= 1'b1;
			cal_pattern_bit <= p;
			@(posedge core_clk);
			#1;
			chk("upper_dq", 16'(upper_dq), 16'({8{p}} ^ 8'(inv)));
			chk("mask_line", 16'(mask_line), 16'(p));
			chk("dbi_cal", 16'(dbi_apply), 16'h0000);
		end
		@(posedge core_clk);
		cal_active <= 1'b0;
		@(posedge core_clk);
		#1;
		chk("dbi_idle", 16'(dbi_apply), 16'h0001);
	endtask : cal
	task automatic osc_run_ticks(output int n);
		logic t;
		n = 0;
		for (int i = 0; i < 40; i++) begin
			t = rnd() % 2;
			@(posedge core_clk);
			osc_run <= 1'b1;
			osc_tick <= t;
			n += t;
		end
		@(posedge core_clk);
		osc_run <= 1'b0;
		osc_tick <= 1'b0;
	endtask : osc_run_ticks
	initial begin
		repeat (100000) @(posedge core_clk);
		failures++;
		conclude();
	end
	// ==========================================================
	// main sequence
	initial begin
		logic [7:0] d;
		logic [15:0] c;
		logic v;
		int n;
		repeat (2) @(posedge link_clk);
		rst_b <= 1'b1;
		settle();
		for (int i = 0; i < 8; i++) sref(3'(i), {3'(i), 12'(rnd())});
		cal();
		$display("test reset done");
		bm = rnd() % 256;
		sm = rnd() % 256;
		inv = rnd() % 256;
		u_mc.mrw(lmr_pkg::MA_BANK_MASK, 8'(bm));
		u_mc.mrw(lmr_pkg::MA_SEG_MASK, 8'(sm));
		u_mc.mrw(lmr_pkg::MA_RSVD, 8'(rnd()));
		u_mc.mrw(lmr_pkg::MA_INVERT, 8'(inv));
		settle();
		for (int i = 0; i < 64; i++) sref(3'(i), {3'(i >> 3), 12'(rnd())});
		foreach (wo_addr[k]) begin
			u_mc.mrr(wo_addr[k], d, v);
			chk("wo_read", {7'h00, v, d}, 16'h0100);
		end
		cal();
		$display("test masks done");
		term[0] = rnd() % 256;
		term[1] = rnd() % 256;
		for (int w = 0; w < 2; w++) begin
			u_mc.set_sp(w[0], 1'b0);
			u_mc.mrw(lmr_pkg::MA_TERM, 8'(term[w]));
		end
		for (int w = 0; w < 2; w++) begin
			u_mc.set_sp(w[0], w[0]);
			u_mc.mrr(lmr_pkg::MA_TERM, d, v);
			chk("term_read", 16'(d), 16'(term[w]));
			repeat (3) @(posedge link_clk);
			#1;
			chk("term_active", 16'(term_active), 16'(term[w]));
			chk("term_ca", 16'(term_active.command_address_termination_disable), 16'(term[w][5]));
		end
		$display("test termination done");
		osc_run_ticks(n);
		u_mc.start_osc();
		settle();
		osc_run_ticks(n);
		settle();
		u_mc.rd_count(c, v);
		chk("osc_count", c, 16'(n));
		chk("osc_valid", 16'(v), 16'h0001);
		u_mc.start_osc();
		settle();
		u_mc.rd_count(c, v);
		chk("osc_cleared", c, 16'h0000);
		chk("osc_valid", 16'(v), 16'h0001);
		$display("test oscillator done");
		conclude();
	end
endmodule : tb

`default_nettype wire
